// ---- common/irq_dma_route_pkg.sv ----
/*
  Package for the interrupt and DMA routing configuration slice: register
  indices, reset values, field positions and pin carriers.
  Assumes a single core clock and a synchronous active-high reset.
*/
package irq_dma_route_pkg;

  localparam int DATA_W = 8;
  localparam int IRQ_LINES = 7;
  localparam int DMA_CHANNELS = 3;

  localparam logic [7:0] IDX_SERIAL_IRQ = 8'h28;
  localparam logic [7:0] IDX_INPUT_PIN_IRQ = 8'h29;
  localparam logic [7:0] IDX_RESERVED_2A = 8'h2a;
  localparam logic [7:0] IDX_ENGINE_BASE = 8'h2b;
  localparam logic [7:0] IDX_ENGINE_DMA = 8'h2c;
  localparam logic [7:0] IDX_RESERVED_2D = 8'h2d;
  localparam logic [7:0] IDX_SCRATCH_A = 8'h2e;
  localparam logic [7:0] IDX_SCRATCH_B = 8'h2f;

  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_RESERVED_2D = 8'h03;

  localparam logic [3:0] IRQ_CODE_NONE = 4'h0;
  localparam logic [3:0] IRQ_CODE_LAST_LOW = 4'h6;
  localparam logic [3:0] IRQ_CODE_LINE_H = 4'h8;
  localparam logic [3:0] IRQ_CODE_SHARE = 4'hf;
  localparam int IRQ_INDEX_H = 6;

  localparam logic [3:0] DMA_CODE_LAST = 4'h3;

  localparam logic [3:0] LOW_NIBBLE_MASK = 4'hf;
  localparam logic [7:0] LOW_NIBBLE_ONLY = 8'h0f;
  localparam logic [2:0] BASE_TOP_ZERO = 3'h0;

  // Lines A..F, H in bits 0..6
  typedef struct packed {
    logic [IRQ_LINES-1:0] out;
    logic [IRQ_LINES-1:0] oe;
  } irq_pins_t;

  typedef struct packed {
    logic [DMA_CHANNELS-1:0] out;
    logic [DMA_CHANNELS-1:0] oe;
  } dma_pins_t;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] wdata;
    logic write;
    logic read;
  } cfg_access_t;

endpackage

// ---- design/engine_addr_match.sv ----
/*
  Address match for the auxiliary engine: compares bits 10..3 of the I/O
  address against the base register while the device is selected.
  Assumes address and select are already synchronised to core_clk.
*/
module engine_addr_match (
  input wire logic [7:0] base,
  input wire logic [10:0] io_addr,
  input wire logic device_select_n,
  output logic hit
);

  logic decode_on;

  assign decode_on = base[7:5] != irq_dma_route_pkg::BASE_TOP_ZERO;
  // Low three address bits are don't-care
  assign hit = decode_on && !device_select_n && (io_addr[10:3] == base);

endmodule

// ---- design/irq_dma_route_config.sv ----
/*
  Configuration slice routing both serial port interrupts, the external
  interrupt input and the auxiliary engine DMA request onto shared pins,
  plus the engine base decode and two scratch registers.
  Assumes the ISA front end delivers one-cycle read and write strobes
  with the current configuration index and a config-state level, all on
  core_clk. Interrupt and DMA sources come from logic on the same clock,
  except the external interrupt input, which is a pin.
*/
// Summary of operation
// - Access only in configuration state with index matching the register.
// - Routing, reserved 0x2A, base, DMA and scratch registers reset to zero.
// - Serial register high nibble routes port one, low nibble port two.
// - Code 0 none, 1..6 lines A..F, 7 reserved, 8 line H.
// - Interrupt pins nobody selects float.
// - Port two code fifteen selects sharing mode.
// - Input-pin register low nibble routes external interrupt input.
// - Upper nibbles of input-pin and DMA registers read zero, ignore writes.
// - Engine base holds address bits 10..3, eight-byte aligned.
// - Base bits 10..8 all zero disable engine decode.
// - Engine access needs select low and match above bit two.
// - DMA code 0 none, 1..3 channels A..C.
// - Unused DMA request outputs float.
// - Reserved register 0x2D resets to three.
// - Scratch A at 0x2E, reset zero, no effect.
// - Scratch B at 0x2F, reset zero, no effect.
// - Index 0x2A is reserved and resets to zero.
module irq_dma_route_config (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic config_state,
  input wire irq_dma_route_pkg::cfg_access_t cfg,
  output logic [7:0] cfg_rdata,
  output logic cfg_rdata_valid,
  input wire logic [1:0] port_irq,
  input wire logic [1:0] port_irq_output_enable,
  input wire logic external_irq_input,
  input wire logic engine_irq,
  input wire logic engine_dma_req,
  input wire logic [10:0] io_addr,
  input wire logic device_select_n,
  output logic engine_select,
  output logic [7:0] engine_base_address_out,
  output irq_dma_route_pkg::irq_pins_t irq_pins,
  output irq_dma_route_pkg::dma_pins_t dma_pins
);

  logic [7:0] serial_irq_select;
  logic [3:0] input_pin_irq_select;
  logic [7:0] reserved_index_2a;
  logic [7:0] engine_base_address;
  logic [3:0] engine_dma_select;
  logic [7:0] reserved_index_2d;
  logic [7:0] software_scratch_a;
  logic [7:0] software_scratch_b;
  logic ext_irq_meta;
  logic ext_irq_sync;
  logic wr_ok;
  logic rd_ok;
  logic share_mode;
  logic [1:0] port_drive;
  logic [1:0] port_level;
  logic [irq_dma_route_pkg::IRQ_LINES-1:0] port1_lines;
  logic [irq_dma_route_pkg::IRQ_LINES-1:0] port2_lines;
  logic [irq_dma_route_pkg::IRQ_LINES-1:0] ext_lines;
  logic [irq_dma_route_pkg::IRQ_LINES-1:0] next_irq_oe;
  logic [irq_dma_route_pkg::IRQ_LINES-1:0] next_irq_out;
  logic [irq_dma_route_pkg::DMA_CHANNELS-1:0] next_dma_oe;
  logic [irq_dma_route_pkg::DMA_CHANNELS-1:0] next_dma_out;
  logic [7:0] next_rdata;
  logic next_engine_select;

  // Config-state gating: strobes outside configuration state are dropped
  assign wr_ok = config_state && cfg.write;
  assign rd_ok = config_state && cfg.read;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      serial_irq_select <= irq_dma_route_pkg::RESET_ZERO;
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_SERIAL_IRQ) begin
      serial_irq_select <= cfg.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      input_pin_irq_select <= irq_dma_route_pkg::RESET_ZERO[3:0];
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_INPUT_PIN_IRQ) begin
      input_pin_irq_select <= cfg.wdata[3:0];
    end
  end

  // Reserved index: storage kept so software reads back what it wrote
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reserved_index_2a <= irq_dma_route_pkg::RESET_ZERO;
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_RESERVED_2A) begin
      reserved_index_2a <= cfg.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engine_base_address <= irq_dma_route_pkg::RESET_ZERO;
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_ENGINE_BASE) begin
      engine_base_address <= cfg.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engine_dma_select <= irq_dma_route_pkg::RESET_ZERO[3:0];
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_ENGINE_DMA) begin
      engine_dma_select <= cfg.wdata[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reserved_index_2d <= irq_dma_route_pkg::RESET_RESERVED_2D;
    end else if (wr_ok && cfg.index == irq_dma_route_pkg::IDX_RESERVED_2D) begin
      reserved_index_2d <= cfg.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      software_scratch_a <= irq_dma_route_pkg::RESET_ZERO;
      software_scratch_b <= irq_dma_route_pkg::RESET_ZERO;
    end else if (wr_ok) begin
      if (cfg.index == irq_dma_route_pkg::IDX_SCRATCH_A) begin
        software_scratch_a <= cfg.wdata;
      end
      if (cfg.index == irq_dma_route_pkg::IDX_SCRATCH_B) begin
        software_scratch_b <= cfg.wdata;
      end
    end
  end

  always_comb begin
    next_rdata = irq_dma_route_pkg::RESET_ZERO;
    if (cfg.index == irq_dma_route_pkg::IDX_SERIAL_IRQ) begin
      next_rdata = serial_irq_select;
    end else if (cfg.index == irq_dma_route_pkg::IDX_INPUT_PIN_IRQ) begin
      next_rdata = {4'h0, input_pin_irq_select};
    end else if (cfg.index == irq_dma_route_pkg::IDX_RESERVED_2A) begin
      next_rdata = reserved_index_2a;
    end else if (cfg.index == irq_dma_route_pkg::IDX_ENGINE_BASE) begin
      next_rdata = engine_base_address;
    end else if (cfg.index == irq_dma_route_pkg::IDX_ENGINE_DMA) begin
      next_rdata = {4'h0, engine_dma_select};
    end else if (cfg.index == irq_dma_route_pkg::IDX_RESERVED_2D) begin
      next_rdata = reserved_index_2d;
    end else if (cfg.index == irq_dma_route_pkg::IDX_SCRATCH_A) begin
      next_rdata = software_scratch_a;
    end else if (cfg.index == irq_dma_route_pkg::IDX_SCRATCH_B) begin
      next_rdata = software_scratch_b;
    end
  end

  // Read data registered; unmapped indices and reads outside config state give zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg_rdata <= irq_dma_route_pkg::RESET_ZERO;
      cfg_rdata_valid <= 1'b0;
    end else begin
      cfg_rdata <= rd_ok ? next_rdata : irq_dma_route_pkg::RESET_ZERO;
      cfg_rdata_valid <= rd_ok;
    end
  end

  // External interrupt pin is asynchronous
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ext_irq_meta <= 1'b0;
      ext_irq_sync <= 1'b0;
    end else begin
      ext_irq_meta <= external_irq_input;
      ext_irq_sync <= ext_irq_meta;
    end
  end

  assign share_mode = serial_irq_select[3:0] == irq_dma_route_pkg::IRQ_CODE_SHARE;

  // Per-port pin drive: enable gates driving, interrupt gives the level
  always_comb begin
    if (share_mode) begin
      port_drive[0] = |port_irq_output_enable;
      port_level[0] = |(port_irq & port_irq_output_enable);
      port_drive[1] = 1'b0;
      port_level[1] = 1'b0;
    end else begin
      port_drive = port_irq_output_enable;
      port_level = port_irq & port_irq_output_enable;
    end
  end

  irq_line_decoder u_port1_dec (
    .code(serial_irq_select[7:4]),
    .lines(port1_lines)
  );

  irq_line_decoder u_port2_dec (
    .code(share_mode ? irq_dma_route_pkg::IRQ_CODE_NONE : serial_irq_select[3:0]),
    .lines(port2_lines)
  );

  irq_line_decoder u_ext_dec (
    .code(input_pin_irq_select),
    .lines(ext_lines)
  );

  // Software must not route two sources to one line; if it does, OR wins
  always_comb begin
    next_irq_oe = '0;
    next_irq_out = '0;
    for (int i = 0; i < irq_dma_route_pkg::IRQ_LINES; i++) begin
      if (port1_lines[i] && port_drive[0]) begin
        next_irq_oe[i] = 1'b1;
        next_irq_out[i] = next_irq_out[i] | port_level[0];
      end
      if (port2_lines[i] && port_drive[1]) begin
        next_irq_oe[i] = 1'b1;
        next_irq_out[i] = next_irq_out[i] | port_level[1];
      end
      if (ext_lines[i]) begin
        next_irq_oe[i] = 1'b1;
        next_irq_out[i] = next_irq_out[i] | ext_irq_sync;
      end
    end
  end

  // Unselected lines stay with enable low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_pins <= '0;
    end else begin
      irq_pins.oe <= next_irq_oe;
      irq_pins.out <= next_irq_out;
    end
  end

  always_comb begin
    next_dma_oe = '0;
    next_dma_out = '0;
    if (engine_dma_select != irq_dma_route_pkg::IRQ_CODE_NONE &&
        engine_dma_select <= irq_dma_route_pkg::DMA_CODE_LAST) begin
      next_dma_oe[2'(engine_dma_select - 4'h1)] = 1'b1;
      next_dma_out[2'(engine_dma_select - 4'h1)] = engine_dma_req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dma_pins <= '0;
    end else begin
      dma_pins.oe <= next_dma_oe;
      dma_pins.out <= next_dma_out;
    end
  end

  engine_addr_match u_engine_match (
    .base(engine_base_address),
    .io_addr(io_addr),
    .device_select_n(device_select_n),
    .hit(next_engine_select)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      engine_select <= 1'b0;
    end else begin
      engine_select <= next_engine_select;
    end
  end

  assign engine_base_address_out = engine_base_address;

  // Engine interrupt is routed elsewhere; kept as an input for the slice port list
  logic unused_engine_irq;
  assign unused_engine_irq = engine_irq;

  property p_write_gated;
    @(posedge core_clk) disable iff (reset)
      (!config_state && cfg.write) |=> $stable(software_scratch_a) && $stable(serial_irq_select);
  endproperty
  a_write_gated: assert property (p_write_gated) else $error("write taken outside config state");

  property p_reset_values;
    @(posedge core_clk) reset |=> reserved_index_2d == 8'h03 && serial_irq_select == 8'h00;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_upper_zero;
    @(posedge core_clk) disable iff (reset)
      (rd_ok && cfg.index == irq_dma_route_pkg::IDX_ENGINE_DMA) |=> cfg_rdata[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved nibble not zero");

  property p_share_port2_float;
    @(posedge core_clk) disable iff (reset)
      share_mode && input_pin_irq_select == 4'h0 && serial_irq_select[7:4] == 4'h0
      |=> irq_pins.oe == '0;
  endproperty
  a_share_port2_float: assert property (p_share_port2_float) else $error("pin driven unrouted");

  property p_share_or;
    @(posedge core_clk) disable iff (reset)
      share_mode && serial_irq_select[7:4] == 4'h1 && input_pin_irq_select == 4'h0 &&
      port_irq_output_enable[1] && port_irq[1] |=> irq_pins.oe[0] && irq_pins.out[0];
  endproperty
  a_share_or: assert property (p_share_or) else $error("shared line not driven");

  property p_dma_none;
    @(posedge core_clk) disable iff (reset)
      engine_dma_select == 4'h0 ##1 engine_dma_select == 4'h0 |-> dma_pins.oe == '0;
  endproperty
  a_dma_none: assert property (p_dma_none) else $error("DMA driven with no channel");

  property p_dma_chan_b;
    @(posedge core_clk) disable iff (reset)
      engine_dma_select == 4'h2 |=> dma_pins.oe == 3'b010 && dma_pins.out[1] == $past(engine_dma_req);
  endproperty
  a_dma_chan_b: assert property (p_dma_chan_b) else $error("DMA channel B wrong");

  property p_engine_off;
    @(posedge core_clk) disable iff (reset)
      engine_base_address[7:5] == 3'h0 |=> !engine_select;
  endproperty
  a_engine_off: assert property (p_engine_off) else $error("engine decode while disabled");

  property p_line_h;
    @(posedge core_clk) disable iff (reset)
      serial_irq_select[7:4] == 4'h8 && !share_mode && port_irq_output_enable[0]
      |=> irq_pins.oe[6];
  endproperty
  a_line_h: assert property (p_line_h) else $error("line H not driven");

  c_share: cover property (@(posedge core_clk) share_mode && irq_pins.out[0]);
  c_engine_hit: cover property (@(posedge core_clk) engine_select);
  c_dma_c: cover property (@(posedge core_clk) dma_pins.oe[2]);
  c_scratch_read: cover property (@(posedge core_clk) cfg_rdata_valid && cfg_rdata != 8'h00);

endmodule

// ---- design/irq_line_decoder.sv ----
/*
  Decodes a four-bit interrupt routing code into a one-hot line vector.
  Assumes the caller masks out the sharing code where it applies.
*/
module irq_line_decoder (
  input wire logic [3:0] code,
  output logic [irq_dma_route_pkg::IRQ_LINES-1:0] lines
);

  always_comb begin
    lines = '0;
    if (code == irq_dma_route_pkg::IRQ_CODE_LINE_H) begin
      lines[irq_dma_route_pkg::IRQ_INDEX_H] = 1'b1;
    end else if (code != irq_dma_route_pkg::IRQ_CODE_NONE &&
                 code <= irq_dma_route_pkg::IRQ_CODE_LAST_LOW) begin
      lines[3'(code - 4'h1)] = 1'b1;
    end
  end

endmodule

// ---- test/cfg_host_model.sv ----
/*
  Host-side model of the configuration access path: drives the config
  state level, the index, the write data and one-cycle read/write strobes.
  Assumes the block returns registered read data one cycle after a read.
*/
module cfg_host_model (
  input wire logic core_clk,
  output logic config_state,
  output irq_dma_route_pkg::cfg_access_t cfg,
  input wire logic [7:0] cfg_rdata,
  input wire logic cfg_rdata_valid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    config_state = 1'b0;
    cfg = '0;
  end

  // Registers are only reached while the config state level is held
  task automatic set_state(input logic on);
    @(posedge core_clk);
    config_state <= on;
  endtask

  // Index is presented with the strobe; each register answers only to its own
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    @(posedge core_clk);
    cfg.index <= idx;
    cfg.wdata <= data;
    cfg.write <= 1'b1;
    @(posedge core_clk);
    cfg.write <= 1'b0;
    // Released data shows the inverse so a stale value cannot pass
    cfg.wdata <= ~data;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] data, output logic valid);
    @(posedge core_clk);
    cfg.index <= idx;
    cfg.read <= 1'b1;
    @(posedge core_clk);
    cfg.read <= 1'b0;
    #1;
    data = cfg_rdata;
    valid = cfg_rdata_valid;
  endtask
endmodule

// ---- test/testbench.sv ----
/*
  Self-checking bench for the interrupt and DMA routing slice.
  Assumes the host model drives the config path and the bench drives
  the interrupt, DMA and address sources on the rising clock edge.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic reset;
  logic config_state;
  irq_dma_route_pkg::cfg_access_t cfg;
  logic [7:0] cfg_rdata;
  logic cfg_rdata_valid;
  logic [1:0] port_irq;
  logic [1:0] port_irq_output_enable;
  logic external_irq_input;
  logic engine_dma_req;
  logic [10:0] io_addr;
  logic device_select_n;
  logic engine_select;
  logic [7:0] engine_base_address_out;
  irq_dma_route_pkg::irq_pins_t irq_pins;
  irq_dma_route_pkg::dma_pins_t dma_pins;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rdat;
  logic rval;
  logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};

  irq_dma_route_config DUT (
    .core_clk(core_clk), .reset(reset), .config_state(config_state), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid), .port_irq(port_irq),
    .port_irq_output_enable(port_irq_output_enable), .external_irq_input(external_irq_input),
    .engine_irq(1'b0), .engine_dma_req(engine_dma_req), .io_addr(io_addr),
    .device_select_n(device_select_n), .engine_select(engine_select),
    .engine_base_address_out(engine_base_address_out), .irq_pins(irq_pins),
    .dma_pins(dma_pins)
  );

  cfg_host_model host (
    .core_clk(core_clk), .config_state(config_state), .cfg(cfg),
    .cfg_rdata(cfg_rdata), .cfg_rdata_valid(cfg_rdata_valid)
  );

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic bad(input string msg);
    num_errors++;
    $display("BAD %0t %s", $time, msg);
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("byte got %h expected %h", got, exp));
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) bad($sformatf("flag got %b expected %b", got, exp));
  endtask

  // Level is only compared where the pin drives; a floating pin has no level
  task automatic chk_irq(input logic [6:0] oe, input logic [6:0] hi);
    samples_checked++;
    if (irq_pins.oe !== oe || (irq_pins.out & oe) !== hi) begin
      bad($sformatf("irq oe %b out %b expected %b %b", irq_pins.oe, irq_pins.out, oe, hi));
    end
  endtask

  task automatic chk_dma(input logic [2:0] oe, input logic [2:0] hi);
    samples_checked++;
    if (dma_pins.oe !== oe || (dma_pins.out & oe) !== hi) begin
      bad($sformatf("dma oe %b out %b expected %b %b", dma_pins.oe, dma_pins.out, oe, hi));
    end
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic v);
    host.rd(idx, rdat, rval);
    chk_reg(rdat, exp);
    chk_bit(rval, v);
  endtask

  // Sources change on an edge; four cycles covers the slowest path
  task automatic src(input logic [1:0] q, input logic [1:0] en, input logic ext,
                     input logic dreq);
    @(posedge core_clk);
    port_irq <= q;
    port_irq_output_enable <= en;
    external_irq_input <= ext;
    engine_dma_req <= dreq;
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  task automatic eng(input logic [7:0] base, input logic [10:0] addr, input logic sn,
                     input logic exp);
    host.wr(8'h28 + 8'h03, base);
    @(posedge core_clk);
    io_addr <= addr;
    device_select_n <= sn;
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(engine_select, exp);
    chk_reg(engine_base_address_out, base);
  endtask

  function automatic logic [6:0] line(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'h6) return 7'h01 << (c - 4'h1);
    if (c == 4'h8) return 7'h40;
    return 7'h00;
  endfunction

  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    port_irq = 2'h0;
    port_irq_output_enable = 2'h0;
    external_irq_input = 1'b0;
    engine_dma_req = 1'b0;
    io_addr = 11'h000;
    device_select_n = 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    host.set_state(1'b1);
    for (int i = 0; i < 8; i++) rd_chk(8'h28 + 8'(i), rst_exp[i], 1'b1);
    chk_irq(7'h00, 7'h00);
    chk_dma(3'h0, 3'h0);
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h28 + 8'(i), 8'hff);
      rd_chk(8'h28 + 8'(i), (i == 1 || i == 4) ? 8'h0f : 8'hff, 1'b1);
      host.wr(8'h28 + 8'(i), 8'h00);
    end
    host.wr(8'h2e, 8'ha5);
    host.wr(8'h2f, 8'h3c);
    rd_chk(8'h2e, 8'ha5, 1'b1);
    rd_chk(8'h2f, 8'h3c, 1'b1);
    host.set_state(1'b0);
    host.wr(8'h2e, 8'h5a);
    rd_chk(8'h2e, 8'h00, 1'b0);
    host.set_state(1'b1);
    rd_chk(8'h2e, 8'ha5, 1'b1);
    host.wr(8'h30, 8'h77);
    rd_chk(8'h30, 8'h00, 1'b1);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 16 - p; c++) begin
        logic [3:0] cc;
        cc = 4'(c);
        host.wr(8'h28, (p == 0) ? {cc, 4'h0} : {4'h0, cc});
        src(2'b01 << p, 2'b01 << p, 1'b0, 1'b0);
        chk_irq(line(cc), line(cc));
      end
    end
    for (int s = 0; s < 2; s++) begin
      if (s == 0) begin
        host.wr(8'h28, 8'h12);
      end else begin
        // Sharing is entered by routing port one first, then port two code fifteen
        host.wr(8'h28, 8'h10);
        host.wr(8'h28, 8'h1f);
      end
      for (int k = 0; k < 16; k++) begin
        logic [1:0] q;
        logic [1:0] en;
        q = 2'(k);
        en = 2'(k >> 2);
        src(q, en, 1'b0, 1'b0);
        if (s == 0) chk_irq({5'h0, en}, {5'h0, en & q});
        else chk_irq({6'h0, |en}, {6'h0, |(en & q)});
      end
    end
    host.wr(8'h28, 8'h00);
    host.wr(8'h29, 8'h03);
    src(2'h0, 2'h0, 1'b1, 1'b0);
    chk_irq(7'h04, 7'h04);
    src(2'h0, 2'h0, 1'b0, 1'b0);
    chk_irq(7'h04, 7'h00);
    host.wr(8'h29, 8'h00);
    src(2'h0, 2'h0, 1'b0, 1'b0);
    chk_irq(7'h00, 7'h00);
    // Sharing with port one unrouted: both ports raised, yet no pin may drive
    host.wr(8'h28, 8'h0f);
    src(2'h3, 2'h3, 1'b0, 1'b0);
    chk_irq(7'h00, 7'h00);
    for (int c = 0; c < 16; c++) begin
      logic [2:0] e;
      e = (c >= 1 && c <= 3) ? 3'h1 << (c - 1) : 3'h0;
      host.wr(8'h2c, 8'(c));
      src(2'h0, 2'h0, 1'b0, 1'b1);
      chk_dma(e, e);
    end
    host.wr(8'h2c, 8'h02);
    src(2'h0, 2'h0, 1'b0, 1'b0);
    chk_dma(3'h2, 3'h0);
    eng(8'h20, 11'h100, 1'b0, 1'b1);
    eng(8'h20, 11'h107, 1'b0, 1'b1);
    eng(8'h20, 11'h108, 1'b0, 1'b0);
    eng(8'h20, 11'h100, 1'b1, 1'b0);
    eng(8'h1f, 11'h0f8, 1'b0, 1'b0);
    eng(8'hff, 11'h7f8, 1'b0, 1'b1);
    eng(8'he0, 11'h700, 1'b0, 1'b1);
    // A second reset in mid-run must restore the power-up values
    host.wr(8'h2d, 8'h55);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(8'h2d, 8'h03, 1'b1);
    rd_chk(8'h2b, 8'h00, 1'b1);
    conclude();
  end
endmodule
